/* File: tsf_top.sv */
`timescale 1ns/100ps
module tsf_top
   import tsf_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // self-initialization
   input wire logic self_init_select,
   input wire logic init_busy,
   input wire logic eeprom_cksum_fail,
   input wire logic ram_word_mismatch,
   // bus controller
   input wire logic bc_enabled,
   input wire logic bc_executing,
   // monitor
   input wire logic mon_cmd_valid,
   input wire logic mon_msg_done,
   input wire logic mon_pkt_start,
   input wire logic mon_pkt_done,
   input wire logic mon_reset_done,
   // remote terminals, index 0 first terminal, index 1 second
   input wire logic [1:0] rt_cmd_valid,
   input wire logic [1:0] rt_msg_done,
   input wire logic [1:0] rt_shutdown_cmd,
   input wire logic [1:0] rt_shutdown_bus,
   input wire logic [1:0] rt_override_cmd,
   input wire logic [1:0] rt_reset_done,
   // status and control outputs
   output logic ready,
   output logic rt1_soft_reset,
   output logic rt2_soft_reset,
   output logic monitor_soft_reset,
   output logic eeprom_reload_en
);
   typedef struct packed {
      logic [2:0] sync;
      logic filt;
      logic [2:0] cnt;
      logic sampled;
      logic self_init;
      logic ready;
      logic bc_run;
      logic [1:0] inh;
      logic [1:0] inh_bus;
      logic ee_err;
      logic ram_err;
      logic mt_rst;
      logic [1:0] rt_rst;
      logic [1:0] hpi;
   } tsf_top_s;

   tsf_top_s q;
   tsf_top_s d;
   tsf_reg_if rif ();

   logic [3:0] msg_set;
   logic [3:0] msg_clr;
   logic [3:0] msg_flag;
   logic [15:0] msr;
   logic [15:0] hpi_word;
   logic [15:0] bitw [2];
   logic msr_wr;
   logic hpi_rd;

   tsf_apb u_apb
   (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .rif(rif.bus)
   );

   // flag order: rt1 msg, rt2 msg, monitor packet, monitor msg
   assign msg_set = {mon_cmd_valid, mon_pkt_start, rt_cmd_valid[1], rt_cmd_valid[0]};
   assign msg_clr = {mon_msg_done, mon_pkt_done, rt_msg_done[1], rt_msg_done[0]};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_msg
         tsf_flag u_flag
         (
            .pclk(pclk),
            .presetn(presetn),
            .set_evt(msg_set[gi]),
            .clr_evt(msg_clr[gi]),
            .flag(msg_flag[gi])
         );
      end
   endgenerate

   // status words seen by the host
   always_comb
   begin
      msr = REG_RST;
      msr[MSR_READY] = q.ready;
      msr[MSR_SELF] = q.self_init;
      msr[MSR_MTRST] = q.mt_rst;
      msr[MSR_RT2RST] = q.rt_rst[1];
      msr[MSR_RT1RST] = q.rt_rst[0];
      msr[MSR_BCRUN] = q.bc_run;
      msr[MSR_MONMSG] = msg_flag[3];
      msr[MSR_MONPKT] = msg_flag[2];
      msr[MSR_RT2MSG] = msg_flag[1];
      msr[MSR_RT1MSG] = msg_flag[0];
      msr[MSR_RT2_BUS_INHIBITED] = q.inh[1];
      msr[MSR_RT1_BUS_INHIBITED] = q.inh[0];
      msr[MSR_EECK] = q.ee_err;
      msr[MSR_RAM_INIT_MISMATCH] = q.ram_err;
      hpi_word = REG_RST;
      hpi_word[HPI_EECK] = q.hpi[1];
      hpi_word[HPI_RAM_INIT_MISMATCH] = q.hpi[0];
      for (int i = 0; i < 2; i++)
      begin
         bitw[i] = REG_RST;
         bitw[i][BITW_BUS_A] = q.inh[i] & ~q.inh_bus[i];
         bitw[i][BITW_BUS_B] = q.inh[i] & q.inh_bus[i];
      end
   end

   // read mux; while not ready every read returns the status word
   always_comb
   begin
      rif.hit = 1'b1;
      rif.rdata = msr;
      if (q.ready)
      begin
         unique case (rif.idx)
            IDX_MSR: rif.rdata = msr;
            IDX_HPI: rif.rdata = hpi_word;
            IDX_BITW1: rif.rdata = bitw[0];
            IDX_BITW2: rif.rdata = bitw[1];
            default:
            begin
               rif.hit = 1'b0;
               rif.rdata = REG_RST;
            end
         endcase
      end
   end

   // host writes land only when ready; flag bits never take write data
   assign msr_wr = rif.wr_stb & q.ready & (rif.idx == IDX_MSR);
   assign hpi_rd = rif.rd_stb & q.ready & (rif.idx == IDX_HPI);

   always_comb
   begin
      d = q;
      // pin synchroniser; a change counts once stages two and three agree
      d.sync = {q.sync[1:0], self_init_select};
      if (q.sync[1] == q.sync[2])
         d.filt = q.sync[2];
      // strap caught once the synchroniser has filled after release
      if (!q.sampled)
      begin
         if (q.cnt == SAMPLE_CNT)
         begin
            d.sampled = 1'b1;
            d.self_init = q.filt;
         end
         else
            d.cnt = q.cnt + 3'h1;
      end
      d.bc_run = bc_enabled & bc_executing;
      // soft resets: written one starts, done self-clears
      if (msr_wr)
      begin
         d.mt_rst = q.mt_rst | rif.wdata[MSR_MTRST];
         d.rt_rst[1] = q.rt_rst[1] | rif.wdata[MSR_RT2RST];
         d.rt_rst[0] = q.rt_rst[0] | rif.wdata[MSR_RT1RST];
      end
      if (q.mt_rst && mon_reset_done)
         d.mt_rst = 1'b0;
      for (int i = 0; i < 2; i++)
      begin
         if (q.rt_rst[i] && rt_reset_done[i])
            d.rt_rst[i] = 1'b0;
         // ending a shutdown takes priority over a new one
         if (q.rt_rst[i] || rt_override_cmd[i])
         begin
            d.inh[i] = 1'b0;
            d.inh_bus[i] = 1'b0;
         end
         else if (rt_shutdown_cmd[i])
         begin
            d.inh[i] = 1'b1;
            d.inh_bus[i] = rt_shutdown_bus[i];
         end
      end
      // pending bits: read clears, but an event in the same cycle survives
      if (hpi_rd)
         d.hpi = 2'h0;
      if (q.self_init && eeprom_cksum_fail)
      begin
         d.ee_err = 1'b1;
         d.hpi[1] = 1'b1;
      end
      if (q.self_init && ram_word_mismatch)
      begin
         d.ram_err = 1'b1;
         d.hpi[0] = 1'b1;
      end
      d.ready = d.sampled & ~init_busy & ~d.mt_rst & ~(|d.rt_rst);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         q <= '0;
      else
         q <= d;
   end

   assign ready = q.ready;
   assign rt1_soft_reset = q.rt_rst[0];
   assign rt2_soft_reset = q.rt_rst[1];
   assign monitor_soft_reset = q.mt_rst;
   assign eeprom_reload_en = q.self_init;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_BCRUN: assert property ((bc_enabled && bc_executing) |=> q.bc_run ##0 msr[MSR_BCRUN])
      else $error("bc running flag low while enabled and executing");
   AST_MONMSG: assert property (mon_cmd_valid |=> msr[MSR_MONMSG])
      else $error("monitor message flag not set");
   AST_MONPKT: assert property ((mon_pkt_done && !mon_pkt_start) |=> !msr[MSR_MONPKT])
      else $error("monitor packet flag not cleared");
   AST_RT2MSG: assert property (rt_cmd_valid[1] |=> msr[MSR_RT2MSG])
      else $error("second terminal message flag not set");
   AST_RT1MSG: assert property ((rt_msg_done[0] && !rt_cmd_valid[0]) |=> !msr[MSR_RT1MSG])
      else $error("first terminal message flag not cleared");
   AST_RT2_BUS_INHIBITED: assert property ((rt_shutdown_cmd[1] && !rt_override_cmd[1] && !q.rt_rst[1])
      |=> msr[MSR_RT2_BUS_INHIBITED])
      else $error("second terminal inhibit not set");
   AST_RT2END: assert property ((rt_override_cmd[1] || q.rt_rst[1]) |=> !msr[MSR_RT2_BUS_INHIBITED])
      else $error("second terminal inhibit not ended");
   AST_BITW: assert property (q.inh[0] |-> (bitw[0][BITW_BUS_A] != bitw[0][BITW_BUS_B]))
      else $error("test word does not name the shut-down bus");
   AST_RT1_BUS_INHIBITED: assert property ((rt_shutdown_cmd[0] && !rt_override_cmd[0] && !q.rt_rst[0])
      |=> msr[MSR_RT1_BUS_INHIBITED] ##0 (bitw[0][BITW_BUS_B] == $past(rt_shutdown_bus[0])))
      else $error("first terminal inhibit not set");
   AST_RT1END: assert property ((rt_override_cmd[0] || q.rt_rst[0]) |=> !msr[MSR_RT1_BUS_INHIBITED])
      else $error("first terminal inhibit not ended");
   AST_EECK: assert property ((q.self_init && eeprom_cksum_fail) |=> (q.ee_err && hpi_word[HPI_EECK]))
      else $error("checksum failure not recorded");
   AST_EE_GATE: assert property ((q.sampled && !q.self_init && !q.ee_err) |=> !q.ee_err)
      else $error("checksum error set without self-initialization");
   AST_RAM: assert property ((q.self_init && ram_word_mismatch) |=> (q.ram_err && hpi_word[HPI_RAM_INIT_MISMATCH]))
      else $error("ram mismatch not recorded");
   AST_RAM_GATE: assert property ((q.sampled && !q.self_init && !q.ram_err) |=> !q.ram_err)
      else $error("ram mismatch set without self-initialization");
   AST_SOFT: assert property ((q.rt_rst[0] && !rt_reset_done[0]) |=> (q.rt_rst[0] && !ready))
      else $error("soft reset dropped early or ready high");
   AST_HPI_CLR: assert property ((hpi_rd && !eeprom_cksum_fail && !ram_word_mismatch) |=> q.hpi == 2'h0)
      else $error("pending register not cleared by read");
   AST_RO: assert property ((msr_wr && !rt_shutdown_cmd[0] && !rt_override_cmd[0]) |=> $stable(q.inh[0]))
      else $error("host write changed a status flag");

   // opposite side of each message flag, the idle side of the running flag and the second test word
   AST_BC_IDLE: assert property (!(bc_enabled && bc_executing) |=> !msr[MSR_BCRUN])
      else $error("bc running flag high while not enabled and executing");
   AST_MONMSG_CLR: assert property ((mon_msg_done && !mon_cmd_valid) |=> !msr[MSR_MONMSG])
      else $error("monitor message flag not cleared");
   AST_MONPKT_SET: assert property (mon_pkt_start |=> msr[MSR_MONPKT])
      else $error("monitor packet flag not set");
   AST_RT2MSG_CLR: assert property ((rt_msg_done[1] && !rt_cmd_valid[1]) |=> !msr[MSR_RT2MSG])
      else $error("second terminal message flag not cleared");
   AST_RT1MSG_SET: assert property (rt_cmd_valid[0] |=> msr[MSR_RT1MSG])
      else $error("first terminal message flag not set");
   AST_RT2BUS: assert property ((rt_shutdown_cmd[1] && !rt_override_cmd[1] && !q.rt_rst[1])
      |=> (bitw[1][BITW_BUS_B] == $past(rt_shutdown_bus[1])))
      else $error("second test word does not name the shut-down bus");
   AST_BITW_IDLE: assert property (!q.inh[1] |-> (bitw[1] == REG_RST))
      else $error("second test word not zero while not inhibited");
   // error flags have no clear path short of master reset
   AST_EE_KEEP: assert property (q.ee_err |=> q.ee_err)
      else $error("checksum error flag dropped");
   AST_RAM_KEEP: assert property (q.ram_err |=> q.ram_err)
      else $error("ram mismatch flag dropped");
   AST_RST_ZERO: assert property (!q.sampled |-> (!q.ee_err && !q.ram_err && (q.hpi == 2'h0)))
      else $error("error state not zero before the strap is caught");
   AST_RT2SOFT: assert property ((q.rt_rst[1] && !rt_reset_done[1]) |=> (q.rt_rst[1] && !ready))
      else $error("second soft reset dropped early or ready high");
   AST_MTSOFT: assert property ((q.mt_rst && !mon_reset_done) |=> (q.mt_rst && !ready))
      else $error("monitor soft reset dropped early or ready high");
   AST_SOFT_END: assert property ((q.rt_rst[0] && rt_reset_done[0]) |=> !q.rt_rst[0])
      else $error("first soft reset did not clear itself");
   AST_MTSOFT_END: assert property ((q.mt_rst && mon_reset_done) |=> !q.mt_rst)
      else $error("monitor soft reset did not clear itself");
   // a locked read returns the status word, so it must not eat pending bits
   AST_HPI_HOLD: assert property ((!q.ready && !eeprom_cksum_fail && !ram_word_mismatch) |=> $stable(q.hpi))
      else $error("pending register changed while host access locked");
   AST_WR_LOCK: assert property ((rif.wr_stb && !q.ready && !rt_reset_done[0] && !rt_reset_done[1]
      && !mon_reset_done) |=> ($stable(q.rt_rst) && $stable(q.mt_rst)))
      else $error("host write landed while host access locked");
endmodule

/* File: tsf_pkg.sv */
// Function
// - bc_running_flag is high while the bus controller is enabled and executing.
// - monitor_msg_active sets on a decoded monitor command, clears on message end.
// - monitor_packet_active sets at packet start, clears when the packet completes.
// - rt2_msg_active sets on a valid second-terminal command, clears on message end.
// - rt1_msg_active sets on a valid first-terminal command, clears on message end.
// - rt2_bus_inhibited is high while a bus is shut down for the second terminal.
// - second terminal shutdown ends on override, master reset or rt2_soft_reset.
// - the shut-down bus is recorded in that terminal's test word while inhibited.
// - rt1_bus_inhibited is high while a bus is shut down for the first terminal.
// - first terminal shutdown ends on override, master reset or rt1_soft_reset.
// - an EEPROM checksum failure sets eeprom_checksum_error and pending bit 14.
// - checksum checks and soft-reset reloads only when self_init_select sampled high.
// - a RAM word mismatching its EEPROM bytes sets ram_init_mismatch and pending bit 13.
// - RAM mismatch is evaluated only when self-initialization was selected at reset.
// - a soft reset bit stays high until done, then clears; ready is low meanwhile.
// - a host read of the hardware pending register while ready clears it, except bits set in that same cycle.
package tsf_pkg;
   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_MSR = 6'h01;
   localparam logic [5:0] IDX_BITW1 = 6'h02;
   localparam logic [5:0] IDX_BITW2 = 6'h03;
   localparam logic [5:0] IDX_HPI = 6'h06;
   // master status and reset fields
   localparam int MSR_READY = 15;
   localparam int MSR_SELF = 13;
   localparam int MSR_MTRST = 12;
   localparam int MSR_RT2RST = 11;
   localparam int MSR_RT1RST = 10;
   localparam int MSR_BCRUN = 8;
   localparam int MSR_MONMSG = 7;
   localparam int MSR_MONPKT = 6;
   localparam int MSR_RT2MSG = 5;
   localparam int MSR_RT1MSG = 4;
   localparam int MSR_RT2_BUS_INHIBITED = 3;
   localparam int MSR_RT1_BUS_INHIBITED = 2;
   localparam int MSR_EECK = 1;
   localparam int MSR_RAM_INIT_MISMATCH = 0;
   // hardware pending fields
   localparam int HPI_EECK = 14;
   localparam int HPI_RAM_INIT_MISMATCH = 13;
   // test word fields
   localparam int BITW_BUS_A = 0;
   localparam int BITW_BUS_B = 1;
   // reset values and timing
   localparam logic [15:0] REG_RST = 16'h0000;
   localparam logic [2:0] SAMPLE_CNT = 3'h4;
endpackage

/* File: tsf_reg_if.sv */
`timescale 1ns/100ps
interface tsf_reg_if;
   logic wr_stb;
   logic rd_stb;
   logic [5:0] idx;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic hit;
   modport bus (output wr_stb, output rd_stb, output idx, output wdata, input rdata, input hit);
   modport regs (input wr_stb, input rd_stb, input idx, input wdata, output rdata, output hit);
endinterface

/* File: tsf_apb.sv */
`timescale 1ns/100ps
module tsf_apb
   import tsf_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // register side
   tsf_reg_if.bus rif
);
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } tsf_apb_s;

   tsf_apb_s q;
   tsf_apb_s d;
   logic access;
   logic done;
   logic bad;

   // one wait state: the answer is decided in the first access cycle
   always_comb
   begin
      d = q;
      access = psel & penable;
      done = access & q.pready;
      bad = ~rif.hit | (paddr[1:0] != 2'h0);
      rif.idx = paddr[7:2];
      rif.wdata = pwdata[15:0];
      rif.wr_stb = done & pwrite & ~q.pslverr;
      rif.rd_stb = done & ~pwrite & ~q.pslverr;
      if (done)
      begin
         d.pready = 1'b0;
         d.pslverr = 1'b0;
      end
      else if (access)
      begin
         d.pready = 1'b1;
         d.pslverr = bad;
         d.prdata = (bad | pwrite) ? 32'h0 : {16'h0, rif.rdata};
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         q <= '0;
      else
         q <= d;
   end

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;

   AST_PREADY_PULSE: assert property (@(posedge pclk) disable iff (!presetn) pready |=> !pready)
      else $error("pready stood for more than one cycle");
   AST_PREADY_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready) |=> pready)
      else $error("access phase not answered in one wait state");
endmodule

/* File: tsf_flag.sv */
`timescale 1ns/100ps
module tsf_flag
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // events
   input wire logic set_evt,
   input wire logic clr_evt,
   // state
   output logic flag
);
   typedef struct packed {
      logic flag;
   } tsf_flag_s;

   tsf_flag_s q;
   tsf_flag_s d;

   // a new command in the ending cycle starts the next message, so set wins
   always_comb
   begin
      d = q;
      if (set_evt)
         d.flag = 1'b1;
      else if (clr_evt)
         d.flag = 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         q <= '0;
      else
         q <= d;
   end

   assign flag = q.flag;

   AST_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn) set_evt |=> flag)
      else $error("flag did not set after its event");
   AST_FLAG_CLR: assert property (@(posedge pclk) disable iff (!presetn) clr_evt && !set_evt |=> !flag)
      else $error("flag did not clear after its end event");
endmodule

/* File: tsf_host.sv */
`timescale 1ns/100ps
module tsf_host
(
   // clock
   input wire logic pclk,
   // apb request
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   // apb answer
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
   end
   // idle address and data are inverted so the slave cannot lean on stale values
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [15:0] wd,
                       output logic [15:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= {16'h0000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata[15:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~addr;
      pwdata <= ~{16'h0000, wd};
   endtask
endmodule

/* File: terminal_status_flags_bench.sv */
`timescale 1ns/100ps
module terminal_status_flags_bench;
   import tsf_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic self_sel = 1'b1;
   logic init_busy = 1'b0;
   logic bc_en = 1'b0;
   logic bc_ex = 1'b0;
   logic [16:0] ev = 17'h00000;
   logic [1:0] sd_bus = 2'h0;
   logic ready, rt1_sr, rt2_sr, mon_sr, reload_en;
   logic [15:0] d;
   logic e;
   int fail_count = 0;
   int checked = 0;
   always #2.5 pclk = ~pclk;
   tsf_host i_tsf_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   tsf_top i_tsf_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .self_init_select(self_sel), .init_busy(init_busy), .eeprom_cksum_fail(ev[0]),
      .ram_word_mismatch(ev[1]), .bc_enabled(bc_en), .bc_executing(bc_ex), .mon_cmd_valid(ev[2]),
      .mon_msg_done(ev[3]), .mon_pkt_start(ev[4]), .mon_pkt_done(ev[5]), .mon_reset_done(ev[6]),
      .rt_cmd_valid(ev[8:7]), .rt_msg_done(ev[10:9]), .rt_shutdown_cmd(ev[12:11]),
      .rt_shutdown_bus(sd_bus), .rt_override_cmd(ev[14:13]), .rt_reset_done(ev[16:15]),
      .ready(ready), .rt1_soft_reset(rt1_sr), .rt2_soft_reset(rt2_sr), .monitor_soft_reset(mon_sr),
      .eeprom_reload_en(reload_en));
   task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string nm);
      i_tsf_host.xfer(1'b0, a, 16'h0000, d, e);
      check(nm, exp, d);
   endtask
   // one-cycle pulse on the event inputs
   task automatic fire(input logic [16:0] v);
      @(posedge pclk);
      ev <= v;
      @(posedge pclk);
      ev <= 17'h00000;
   endtask
   // bounded wait, since a stuck ready must not hang the run
   task automatic wait_ready();
      for (int i = 0; i < 20 && ready !== 1'b1; i++)
         @(posedge pclk);
      check("ready", 16'h0001, {15'h0000, ready});
   endtask
   task automatic do_reset(input logic s);
      @(posedge pclk);
      presetn <= 1'b0;
      self_sel <= s;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      wait_ready();
   endtask
   task automatic t_regs();
      rd_chk(8'h04, 16'hA000, "status after reset");
      rd_chk(8'h18, 16'h0000, "pending after reset");
      check("reload enable", 16'h0001, {15'h0000, reload_en});
      i_tsf_host.xfer(1'b1, 8'h04, 16'h01FF, d, e);
      rd_chk(8'h04, 16'hA000, "status ignores writes");
      i_tsf_host.xfer(1'b0, 8'h20, 16'h0000, d, e);
      check("unmapped error", 16'h0001, {15'h0000, e});
   endtask
   task automatic t_bc();
      @(posedge pclk);
      bc_en <= 1'b1;
      rd_chk(8'h04, 16'hA000, "bc enabled idle");
      bc_ex <= 1'b1;
      rd_chk(8'h04, 16'hA100, "bc running");
      bc_en <= 1'b0;
      bc_ex <= 1'b0;
      rd_chk(8'h04, 16'hA000, "bc stopped");
   endtask
   task automatic t_msgs();
      fire(17'h00194);
      rd_chk(8'h04, 16'hA0F0, "messages active");
      fire(17'h00608);
      rd_chk(8'h04, 16'hA040, "terminal messages done");
      fire(17'h00020);
      rd_chk(8'h04, 16'hA000, "packet done");
   endtask
   task automatic t_shutdown();
      sd_bus <= 2'h1;
      fire(17'h01800);
      rd_chk(8'h04, 16'hA00C, "both inhibited");
      rd_chk(8'h08, 16'h0002, "first test word bus B");
      rd_chk(8'h0C, 16'h0001, "second test word bus A");
      fire(17'h02000);
      rd_chk(8'h04, 16'hA008, "first override");
      rd_chk(8'h08, 16'h0000, "first test word cleared");
      i_tsf_host.xfer(1'b1, 8'h04, 16'h0800, d, e);
      @(posedge pclk);
      check("ready held low", 16'h0000, {15'h0000, ready});
      check("second soft reset", 16'h0001, {15'h0000, rt2_sr});
      i_tsf_host.xfer(1'b0, 8'h18, 16'h0000, d, e);
      check("status at any address", 16'h2800, d & 16'hA800);
      fire(17'h10000);
      wait_ready();
      rd_chk(8'h04, 16'hA000, "second shutdown ended");
   endtask
   task automatic t_soft();
      sd_bus <= 2'h0;
      fire(17'h01800);
      rd_chk(8'h08, 16'h0001, "first test word bus A");
      fire(17'h04000);
      rd_chk(8'h04, 16'hA004, "second override");
      i_tsf_host.xfer(1'b1, 8'h04, 16'h1400, d, e);
      i_tsf_host.xfer(1'b1, 8'h04, 16'h0800, d, e);
      check("locked write error", 16'h0000, {15'h0000, e});
      check("monitor soft reset", 16'h0001, {15'h0000, mon_sr});
      check("first soft reset", 16'h0001, {15'h0000, rt1_sr});
      check("locked write ignored", 16'h0000, {15'h0000, rt2_sr});
      rd_chk(8'h04, 16'h3400, "soft resets in progress");
      fire(17'h08000);
      @(posedge pclk);
      check("first soft reset done", 16'h0000, {15'h0000, rt1_sr});
      check("ready waits for monitor", 16'h0000, {15'h0000, ready});
      fire(17'h00040);
      wait_ready();
      check("monitor soft reset done", 16'h0000, {15'h0000, mon_sr});
      rd_chk(8'h04, 16'hA000, "soft resets ended");
      i_tsf_host.xfer(1'b0, 8'h05, 16'h0000, d, e);
      check("misaligned error", 16'h0001, {15'h0000, e});
      check("misaligned data", 16'h0000, d);
   endtask
   task automatic t_errors();
      fire(17'h00003);
      rd_chk(8'h04, 16'hA003, "error flags");
      rd_chk(8'h18, 16'h6000, "pending set");
      rd_chk(8'h18, 16'h0000, "pending read clears");
      rd_chk(8'h04, 16'hA003, "error flags stay");
   endtask
   task automatic t_no_self_init();
      fire(17'h00800);
      do_reset(1'b0);
      rd_chk(8'h04, 16'h8000, "master reset clears");
      check("reload disabled", 16'h0000, {15'h0000, reload_en});
      fire(17'h00003);
      rd_chk(8'h04, 16'h8000, "errors ignored");
      rd_chk(8'h18, 16'h0000, "no pending");
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      do_reset(1'b1);
      t_regs();
      t_bc();
      t_msgs();
      t_shutdown();
      t_soft();
      t_errors();
      t_no_self_init();
      finish_test();
   end
   // the whole sequence needs well under a thousand cycles
   initial
   begin
      #(5 * 5000);
      fail_count++;
      finish_test();
   end
endmodule
